// ==== inc/flash_seq_defs.svh ====
// Purpose: Named constants for the flash self-programming sequencer.
// Assumes: 50 MHz system clock, APB register window with byte addresses.
// Notes: Definitions only; included by bare name.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// ==========================================================
// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_PTR_LO 8'h04
`define ADDR_PTR_HI 8'h08
`define ADDR_DATA_LO 8'h0c
`define ADDR_DATA_HI 8'h10
`define ADDR_LOCK 8'h14

// ==========================================================
// Control register fields
`define CTRL_OPEN 0
`define CTRL_RELEASE 4
`define CTRL_BUSY 6
`define CTRL_IE 7
`define CMD_LSB 0
`define CMD_MSB 4
`define CMD_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_RELEASE 5'h11

// ==========================================================
// Pointer and data fields
`define WORD_LSB 1
`define PAGE_LSB 6
`define DATA_LOCK_LO 4
`define DATA_LOCK_HI 5
`define LOCK_RESET 2'h3
`define ERASED_WORD 16'hffff

// ==========================================================
// Timing
`define ARM_CYCLES 3'h4
`define CLK_PERIOD_NS 20
`define PROG_TIME_MIN_NS 3700000
`define PROG_TIME_MAX_NS 4500000
`define PROG_CYCLES ((`PROG_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== inc/flash_seq_pkg.sv ====
// Purpose: Types shared by the flash self-programming sequencer.
// Assumes: Compiled before any design file.
// Notes: Constants live in flash_seq_defs.svh.
package flash_seq_pkg;

   // ==========================================================
   // Sequencer states, Gray coded along idle, armed, busy
   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'h0,
      SEQ_ARMED = 2'h1,
      SEQ_BUSY = 2'h3
   } seq_state_t;

endpackage

// ==== hdl/prog_timer.sv ====
// Purpose: Times one flash programming operation.
// Assumes: start is a one-cycle pulse given only while idle.
// Notes: done is a one-cycle pulse on the last cycle of the operation.
`timescale 1ns/1ns
`default_nettype none

module prog_timer
#(
   parameter int unsigned CYCLES = 185000
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   output logic done,
   output logic running
);

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] remain;

   // ==========================================================
   // Down counter
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         remain <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !running)
         begin
            remain <= CW'(CYCLES - 1);
            running <= 1'b1;
         end
         else if (running)
         begin
            if (remain == CW'(1))
            begin
               done <= 1'b1;
            end
            if (remain == '0)
            begin
               running <= 1'b0;
            end
            else
            begin
               remain <= remain - CW'(1);
            end
         end
      end
   end

endmodule // prog_timer

`default_nettype wire

// ==== hdl/flash_self_program_sequencer.sv ====
// Purpose: Flash self-programming sequencer with APB registers and page buffer.
// Assumes: CPU strobes come from logic on clk_sys; flash array is outside.
// Notes: Programming time uses the minimum figure, rounded up to whole clock cycles.
`timescale 1ns/1ns
`default_nettype none

`include "flash_seq_defs.svh"

module flash_self_program_sequencer
#(
   parameter int unsigned ADDR_BITS = 14,
   parameter int unsigned PAGE_WORDS = 32,
   parameter logic [13:0] BOOT_START = 14'h3800,
   parameter logic [13:0] STALL_START = 14'h3800,
   parameter int unsigned PROG_CYCLES = `PROG_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic spmExec,
   input wire logic lpmExec,
   input wire logic execInBoot,
   input wire logic vectorsInApp,
   input wire logic eepromWrite,
   input wire logic [15:0] flashRdWord,
   output logic [ADDR_BITS-1:0] flashRdAddr,
   output logic [7:0] lpmData,
   output logic lpmValid,
   output logic lpmDenied,
   output logic flashErase,
   output logic flashLock,
   output logic [1:0] flashLockBits,
   output logic [ADDR_BITS-1:0] flashPage,
   output logic flashWrEn,
   output logic [4:0] flashWrIdx,
   output logic [15:0] flashWrData,
   output logic spmDenied,
   output logic cpuHalt,
   output logic rwwReadBlock,
   output logic appIntMask,
   output logic spmIrq
);

   // ==========================================================
   // Declarations
   logic [7:0] pointerLowReg;
   logic [7:0] pointerHighReg;
   logic [7:0] dataLow;
   logic [7:0] dataHigh;
   logic selfProgOpEnable;
   logic [4:0] cmdBits;
   logic intEnable;
   logic sectionBusyFlag;
   logic bootProtectHi;
   logic bootProtectLo;
   flash_seq_pkg::seq_state_t state;
   logic [2:0] armCnt;
   logic [4:0] activeCmd;
   logic [15:0] pageBuf [0:PAGE_WORDS-1];
   logic [PAGE_WORDS-1:0] bufValid;
   logic streaming;
   logic [4:0] streamIdx;
   logic timerDone;
   logic timerRunning;
   logic apbWr;
   logic ctrlWr;
   logic [4:0] wrCmd;
   logic armReq;
   logic spmTaken;
   logic startOp;
   logic denyOp;
   logic [ADDR_BITS-1:0] ptrWord;
   logic lpmBlocked;
   logic lpmPending;
   logic lpmByteSel;
   logic lpmDeny;

   // ==========================================================
   // Address helpers
   function automatic logic [ADDR_BITS-1:0] wordOf(input logic [15:0] z);
      wordOf = z[`WORD_LSB +: ADDR_BITS];
   endfunction

   function automatic logic inBoot(input logic [ADDR_BITS-1:0] w);
      inBoot = (w >= BOOT_START[ADDR_BITS-1:0]);
   endfunction

   function automatic logic inStall(input logic [ADDR_BITS-1:0] w);
      inStall = (w >= STALL_START[ADDR_BITS-1:0]);
   endfunction

   assign ptrWord = wordOf({pointerHighReg, pointerLowReg});
   assign apbWr = psel && penable && pready && pwrite;
   assign ctrlWr = apbWr && (paddr == `ADDR_CTRL);
   assign wrCmd = pwdata[`CMD_MSB:`CMD_LSB];
   // An EEPROM write blocks arming; one that begins after arming does not stop the flash command.
   assign armReq = ctrlWr && pwdata[`CTRL_OPEN] && !eepromWrite && state != flash_seq_pkg::SEQ_BUSY;
   assign spmTaken = (state == flash_seq_pkg::SEQ_ARMED) && spmExec;
   assign denyOp = (cmdBits != `CMD_LOCK) && (cmdBits != `CMD_RELEASE) && (cmdBits != `CMD_LOAD)
      && inBoot(ptrWord) && !bootProtectLo;
   assign startOp = spmTaken && !denyOp
      && (cmdBits == `CMD_ERASE || cmdBits == `CMD_WRITE || cmdBits == `CMD_LOCK);

   // ==========================================================
   // APB slave: zero-wait, pready high in the access phase
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         if (psel && !penable)
         begin
            pslverr <= 1'b0;
            case (paddr)
               `ADDR_CTRL: prdata <= {24'h000000, intEnable, sectionBusyFlag, 1'b0, cmdBits[4:1],
                  selfProgOpEnable};
               `ADDR_PTR_LO: prdata <= {24'h000000, pointerLowReg};
               `ADDR_PTR_HI: prdata <= {24'h000000, pointerHighReg};
               `ADDR_DATA_LO: prdata <= {24'h000000, dataLow};
               `ADDR_DATA_HI: prdata <= {24'h000000, dataHigh};
               `ADDR_LOCK: prdata <= {30'h00000000, bootProtectHi, bootProtectLo};
               default:
               begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Pointer and data registers
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pointerLowReg <= 8'h00;
         pointerHighReg <= 8'h00;
         dataLow <= 8'h00;
         dataHigh <= 8'h00;
      end
      else if (apbWr)
      begin
         if (paddr == `ADDR_PTR_LO)
         begin
            pointerLowReg <= pwdata[7:0];
         end
         if (paddr == `ADDR_PTR_HI)
         begin
            pointerHighReg <= pwdata[7:0];
         end
         if (paddr == `ADDR_DATA_LO)
         begin
            dataLow <= pwdata[7:0];
         end
         if (paddr == `ADDR_DATA_HI)
         begin
            dataHigh <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // Command sequencer
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state <= flash_seq_pkg::SEQ_IDLE;
         selfProgOpEnable <= 1'b0;
         cmdBits <= 5'h00;
         armCnt <= 3'h0;
         activeCmd <= 5'h00;
         flashPage <= '0;
         spmDenied <= 1'b0;
      end
      else
      begin
         spmDenied <= 1'b0;
         case (state)
            flash_seq_pkg::SEQ_IDLE, flash_seq_pkg::SEQ_ARMED:
            begin
               if (spmTaken && !armReq)
               begin
                  spmDenied <= denyOp;
                  if (startOp)
                  begin
                     state <= flash_seq_pkg::SEQ_BUSY;
                     activeCmd <= cmdBits;
                     flashPage <= ptrWord;
                  end
                  else
                  begin
                     state <= flash_seq_pkg::SEQ_IDLE;
                     selfProgOpEnable <= 1'b0;
                     cmdBits <= 5'h00;
                  end
               end
               else if (armReq)
               begin
                  state <= flash_seq_pkg::SEQ_ARMED;
                  selfProgOpEnable <= 1'b1;
                  cmdBits <= wrCmd;
                  armCnt <= `ARM_CYCLES;
               end
               else if (state == flash_seq_pkg::SEQ_ARMED)
               begin
                  if (armCnt == 3'h1)
                  begin
                     state <= flash_seq_pkg::SEQ_IDLE;
                     selfProgOpEnable <= 1'b0;
                     cmdBits <= 5'h00;
                  end
                  armCnt <= armCnt - 3'h1;
               end
            end
            flash_seq_pkg::SEQ_BUSY:
            begin
               if (timerDone)
               begin
                  state <= flash_seq_pkg::SEQ_IDLE;
                  selfProgOpEnable <= 1'b0;
                  cmdBits <= 5'h00;
               end
            end
            default:
            begin
               state <= flash_seq_pkg::SEQ_IDLE;
               selfProgOpEnable <= 1'b0;
               cmdBits <= 5'h00;
            end
         endcase
      end
   end

   prog_timer
   #(
      .CYCLES(PROG_CYCLES)
   )
   opTimer
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(startOp),
      .done(timerDone),
      .running(timerRunning)
   );

   // ==========================================================
   // Interrupt enable and section busy flag
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         intEnable <= 1'b0;
         sectionBusyFlag <= 1'b0;
      end
      else
      begin
         if (ctrlWr)
         begin
            intEnable <= pwdata[`CTRL_IE];
         end
         // The set is placed last so it wins over a release in the same cycle.
         if (ctrlWr && pwdata[`CTRL_RELEASE] && state != flash_seq_pkg::SEQ_BUSY)
         begin
            sectionBusyFlag <= 1'b0;
         end
         if (startOp && cmdBits != `CMD_LOCK)
         begin
            sectionBusyFlag <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Lock bits: only ever programmed towards zero from software
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bootProtectHi <= 1'(`LOCK_RESET >> 1);
         bootProtectLo <= 1'(`LOCK_RESET);
         flashLock <= 1'b0;
         flashLockBits <= `LOCK_RESET;
      end
      else
      begin
         flashLock <= 1'b0;
         if (startOp && cmdBits == `CMD_LOCK)
         begin
            bootProtectHi <= bootProtectHi & dataLow[`DATA_LOCK_HI];
            bootProtectLo <= bootProtectLo & dataLow[`DATA_LOCK_LO];
            flashLockBits <= {bootProtectHi & dataLow[`DATA_LOCK_HI],
               bootProtectLo & dataLow[`DATA_LOCK_LO]};
            flashLock <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Temporary page buffer
   always_ff @(posedge clk_sys)
   begin
      if (spmTaken && !armReq && cmdBits == `CMD_LOAD)
      begin
         pageBuf[ptrWord[4:0]] <= {dataHigh, dataLow};
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         bufValid <= '0;
      end
      else if ((timerDone && activeCmd == `CMD_WRITE)
         || (ctrlWr && pwdata[`CTRL_RELEASE] && state != flash_seq_pkg::SEQ_BUSY))
      begin
         bufValid <= '0;
      end
      else if (eepromWrite && (|bufValid))
      begin
         bufValid <= '0;
      end
      else if (spmTaken && !armReq && cmdBits == `CMD_LOAD)
      begin
         bufValid[ptrWord[4:0]] <= 1'b1;
      end
   end

   // ==========================================================
   // Flash strobes; a page write streams the buffer, unloaded slots stay erased
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         flashErase <= 1'b0;
         flashWrEn <= 1'b0;
         flashWrIdx <= 5'h00;
         flashWrData <= `ERASED_WORD;
         streaming <= 1'b0;
         streamIdx <= 5'h00;
      end
      else
      begin
         flashErase <= startOp && cmdBits == `CMD_ERASE;
         flashWrEn <= streaming;
         flashWrIdx <= streamIdx;
         flashWrData <= bufValid[streamIdx] ? pageBuf[streamIdx] : `ERASED_WORD;
         if (startOp && cmdBits == `CMD_WRITE)
         begin
            streaming <= 1'b1;
            streamIdx <= 5'h00;
         end
         else if (streaming)
         begin
            streamIdx <= streamIdx + 5'h01;
            if (streamIdx == 5'(PAGE_WORDS - 1))
            begin
               streaming <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // CPU-side status outputs
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cpuHalt <= 1'b0;
         rwwReadBlock <= 1'b0;
         appIntMask <= 1'b0;
         spmIrq <= 1'b0;
      end
      else
      begin
         // Halt and block come up the cycle after the start and drop with the timer.
         cpuHalt <= (startOp && cmdBits != `CMD_LOCK && inStall(ptrWord))
            || (cpuHalt && !timerDone);
         rwwReadBlock <= (startOp && cmdBits != `CMD_LOCK) || (rwwReadBlock && !timerDone);
         appIntMask <= !bootProtectHi && execInBoot && vectorsInApp;
         spmIrq <= intEnable && !selfProgOpEnable;
      end
   end

   // ==========================================================
   // Load-program reads, byte addressed
   assign lpmBlocked = inBoot(wordOf({pointerHighReg, pointerLowReg})) && !bootProtectHi
      && !execInBoot;
   assign lpmDeny = lpmBlocked || (sectionBusyFlag && !inStall(ptrWord));

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         flashRdAddr <= '0;
         lpmPending <= 1'b0;
         lpmByteSel <= 1'b0;
         lpmValid <= 1'b0;
         lpmDenied <= 1'b0;
         lpmData <= 8'h00;
      end
      else
      begin
         lpmPending <= lpmExec && !lpmDeny;
         lpmValid <= lpmPending;
         lpmDenied <= lpmExec && lpmDeny;
         if (lpmExec)
         begin
            flashRdAddr <= ptrWord;
            lpmByteSel <= pointerLowReg[0];
         end
         if (lpmPending)
         begin
            lpmData <= lpmByteSel ? flashRdWord[15:8] : flashRdWord[7:0];
         end
      end
   end

endmodule // flash_self_program_sequencer

`default_nettype wire

// ==== verif/flash_seq_sva.sv ====
// Purpose: Port assertions for the flash self-programming sequencer.
// Assumes: One clock domain; bound to every sequencer instance.
// Notes: Only design-driven outputs are judged.
`timescale 1ns/1ns
`default_nettype none

module flash_seq_sva
#(
   parameter int unsigned ADDR_BITS = 14
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic lpmExec,
   input wire logic execInBoot,
   input wire logic vectorsInApp,
   input wire logic [15:0] flashRdWord,
   input wire logic [7:0] lpmData,
   input wire logic lpmValid,
   input wire logic lpmDenied,
   input wire logic flashErase,
   input wire logic flashLock,
   input wire logic [ADDR_BITS-1:0] flashPage,
   input wire logic flashWrEn,
   input wire logic [4:0] flashWrIdx,
   input wire logic spmDenied,
   input wire logic cpuHalt,
   input wire logic rwwReadBlock,
   input wire logic appIntMask,
   input wire logic spmIrq
);
   // ==========================================================
   // Relations between outputs and their causes
   logic [15:0] rdWordQ;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // The read byte is registered one cycle after the array word is seen.
   always_ff @(posedge clk_sys)
   begin
      rdWordQ <= flashRdWord;
   end

   a_halt_in_op: assert property (cpuHalt |-> rwwReadBlock)
      else $error("CPU halted outside an operation");
   a_erase_blocks: assert property (flashErase |-> rwwReadBlock)
      else $error("erase without section read block");
   a_page_latched: assert property (rwwReadBlock && $past(rwwReadBlock) |-> $stable(flashPage))
      else $error("target page moved during operation");
   a_burst_start: assert property ($rose(flashWrEn) |-> flashWrIdx == 5'h00)
      else $error("page write does not start at slot zero");
   a_burst_step: assert property (flashWrEn && flashWrIdx != 5'h1f
      |=> flashWrEn && flashWrIdx == $past(flashWrIdx) + 5'h01)
      else $error("page write burst broken");
   a_lpm_answer: assert property (lpmExec |=> lpmDenied or (##1 lpmValid))
      else $error("load-program got no answer");
   a_lpm_byte: assert property (lpmValid |-> lpmData == rdWordQ[15:8] || lpmData == rdWordQ[7:0])
      else $error("load-program byte not from addressed word");
   a_denied_noop: assert property (spmDenied |-> !rwwReadBlock ##1 !rwwReadBlock)
      else $error("refused store-program started an operation");
   a_lock_alone: assert property (flashLock |-> !flashErase && !flashWrEn)
      else $error("lock write mixed with page operation");
   a_mask_cause: assert property (appIntMask |-> $past(execInBoot) && $past(vectorsInApp))
      else $error("interrupt mask without boot execution");
   a_irq_quiet: assert property (rwwReadBlock && $past(rwwReadBlock) |-> !spmIrq)
      else $error("interrupt raised while operation runs");
endmodule // flash_seq_sva

bind flash_self_program_sequencer flash_seq_sva #(.ADDR_BITS(ADDR_BITS)) sva_u (.*);

`default_nettype wire

// ==== verif/flash_array_model.sv ====
// Purpose: Read side of the program flash array.
// Assumes: Word read is combinational from the word address.
// Notes: Each word carries the low eight bits of its address, so a wrong low address byte shows as a wrong byte.
`timescale 1ns/1ns
`default_nettype none

module flash_array_model
#(
   parameter int unsigned ADDR_BITS = 14
)
(
   input wire logic [ADDR_BITS-1:0] rdAddr,
   output logic [15:0] rdWord
);
   assign rdWord = {~rdAddr[7:0], rdAddr[7:0]};
endmodule // flash_array_model

`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the flash self-programming sequencer.
// Assumes: Zero-wait APB slave; programming shortened to 20 cycles.
// Notes: A monitor records pulses for later checks.
`timescale 1ns/1ns
`default_nettype none

`include "flash_seq_defs.svh"

module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, spmExec = 1'b0, lpmExec = 1'b0;
   logic execInBoot = 1'b0, vectorsInApp = 1'b0, eepromWrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, lpmValid, lpmDenied, flashErase, flashLock, flashWrEn;
   logic spmDenied, cpuHalt, rwwReadBlock, appIntMask, spmIrq;
   logic [15:0] flashRdWord, flashWrData;
   logic [13:0] flashRdAddr, flashPage;
   logic [7:0] lpmData, lpmByte;
   logic [1:0] flashLockBits;
   logic [4:0] flashWrIdx;
   logic eraseSeen, denySeen, haltSeen, lpmNo;
   logic [15:0] wrBuf [32];
   int bad_count = 0;
   int cmp_count = 0;

   flash_self_program_sequencer #(.PROG_CYCLES(20)) dut_u
   (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .spmExec(spmExec), .lpmExec(lpmExec), .execInBoot(execInBoot),
      .vectorsInApp(vectorsInApp), .eepromWrite(eepromWrite), .flashRdWord(flashRdWord),
      .flashRdAddr(flashRdAddr), .lpmData(lpmData), .lpmValid(lpmValid),
      .lpmDenied(lpmDenied), .flashErase(flashErase), .flashLock(flashLock),
      .flashLockBits(flashLockBits), .flashPage(flashPage), .flashWrEn(flashWrEn),
      .flashWrIdx(flashWrIdx), .flashWrData(flashWrData), .spmDenied(spmDenied),
      .cpuHalt(cpuHalt), .rwwReadBlock(rwwReadBlock), .appIntMask(appIntMask), .spmIrq(spmIrq)
   );

   flash_array_model flash_u (.rdAddr(flashRdAddr), .rdWord(flashRdWord));

   // ==========================================================
   // Clock, monitor and shared tasks
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      if (flashErase) eraseSeen <= 1'b1;
      if (spmDenied) denySeen <= 1'b1;
      if (cpuHalt) haltSeen <= 1'b1;
      if (lpmDenied) lpmNo <= 1'b1;
      if (lpmValid) lpmByte <= lpmData;
      if (flashWrEn) wrBuf[flashWrIdx] <= flashWrData;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         check("pready", 32'h0, 32'h1);
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   // The strobe lands on the first edge after the control write's access edge.
   task automatic cmd(input logic [7:0] c);
      wr(`ADDR_CTRL, {24'h0, c});
      spmExec <= 1'b1;
      @(posedge clk_sys);
      spmExec <= 1'b0;
   endtask

   task automatic setp(input logic [15:0] p);
      wr(`ADDR_PTR_LO, {24'h0, p[7:0]});
      wr(`ADDR_PTR_HI, {24'h0, p[15:8]});
   endtask

   task automatic load(input logic [4:0] slot, input logic [15:0] d);
      setp({10'h0, slot, 1'b0});
      wr(`ADDR_DATA_LO, {24'h0, d[7:0]});
      wr(`ADDR_DATA_HI, {24'h0, d[15:8]});
      cmd(8'h01);
   endtask

   task automatic wait_idle();
      logic [31:0] q;
      int n;
      n = 0;
      do
      begin
         rd(`ADDR_CTRL, q);
         n++;
      end
      while (q[`CTRL_OPEN] !== 1'b0 && n < 100);
      if (n >= 100)
      begin
         check("operation end", 32'h0, 32'h1);
         report_and_stop();
      end
   endtask

   task automatic lpm(input logic [15:0] p);
      setp(p);
      lpmNo = 1'b0;
      lpmExec <= 1'b1;
      @(posedge clk_sys);
      lpmExec <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic clear();
      eraseSeen = 1'b0;
      denySeen = 1'b0;
      haltSeen = 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic scn_reset();
      logic [31:0] q;
      logic e;
      rd(`ADDR_CTRL, q);
      check("ctrl reset", q, 32'h0);
      rd(`ADDR_LOCK, q);
      check("lock reset", q, 32'h3);
      apb(1'b0, 8'h18, 32'h0, q, e);
      check("unmapped error", {31'h0, e}, 32'h1);
   endtask

   task automatic scn_page();
      logic [31:0] q;
      clear();
      load(5'h01, 16'hbeef);
      eepromWrite <= 1'b1;
      repeat (2) @(posedge clk_sys);
      eepromWrite <= 1'b0;
      load(5'h03, 16'h1234);
      load(5'h00, 16'ha55a);
      setp(16'h0040);
      cmd(8'h05);
      rd(`ADDR_CTRL, q);
      check("open during write", {31'h0, q[0]}, 32'h1);
      wait_idle();
      check("slot0", {16'h0, wrBuf[0]}, 32'ha55a);
      check("slot1", {16'h0, wrBuf[1]}, 32'hffff);
      check("slot2", {16'h0, wrBuf[2]}, 32'hffff);
      check("slot3", {16'h0, wrBuf[3]}, 32'h1234);
      check("write page", {18'h0, flashPage}, 32'h0020);
      check("write halt", {31'h0, haltSeen}, 32'h0);
      rd(`ADDR_CTRL, q);
      check("busy set", {31'h0, q[6]}, 32'h1);
      cmd(8'h11);
      rd(`ADDR_CTRL, q);
      check("busy released", {31'h0, q[6]}, 32'h0);
      cmd(8'h05);
      wait_idle();
      check("buffer cleared", {16'h0, wrBuf[3]}, 32'hffff);
      cmd(8'h11);
   endtask

   task automatic scn_irq();
      logic [31:0] q;
      clear();
      wr(`ADDR_CTRL, 32'h80);
      repeat (2) @(posedge clk_sys);
      check("irq idle", {31'h0, spmIrq}, 32'h1);
      setp(16'h0080);
      wr(`ADDR_CTRL, 32'h83);
      repeat (5) @(posedge clk_sys);
      rd(`ADDR_CTRL, q);
      check("arm expiry", {31'h0, q[0]}, 32'h0);
      cmd(8'h00);
      check("late strobe", {31'h0, eraseSeen}, 32'h0);
      cmd(8'h83);
      repeat (3) @(posedge clk_sys);
      check("irq busy", {31'h0, spmIrq}, 32'h0);
      check("erase", {31'h0, eraseSeen}, 32'h1);
      check("erase page", {18'h0, flashPage}, 32'h0040);
      wait_idle();
      repeat (2) @(posedge clk_sys);
      check("irq done", {31'h0, spmIrq}, 32'h1);
      check("app erase halt", {31'h0, haltSeen}, 32'h0);
      cmd(8'h11);
      repeat (2) @(posedge clk_sys);
      check("irq off", {31'h0, spmIrq}, 32'h0);
   endtask

   task automatic scn_lock();
      logic [31:0] q;
      setp(16'hffff);
      wr(`ADDR_DATA_LO, 32'hd0);
      cmd(8'h09);
      wait_idle();
      rd(`ADDR_LOCK, q);
      check("lock mode 4", q, 32'h1);
      check("lock bits", {30'h0, flashLockBits}, 32'h1);
      lpm(16'h0005);
      check("lpm high byte", {24'h0, lpmByte}, 32'hfd);
      lpm(16'h0004);
      check("lpm low byte", {24'h0, lpmByte}, 32'h02);
      lpm(16'h7000);
      check("app reads boot", {31'h0, lpmNo}, 32'h1);
      clear();
      cmd(8'h03);
      wait_idle();
      check("boot erase", {31'h0, eraseSeen}, 32'h1);
      check("stall erase halt", {31'h0, haltSeen}, 32'h1);
      cmd(8'h11);
      wr(`ADDR_DATA_LO, 32'hc0);
      cmd(8'h09);
      wait_idle();
      setp(16'h7000);
      clear();
      cmd(8'h03);
      repeat (3) @(posedge clk_sys);
      check("boot erase refused", {31'h0, denySeen}, 32'h1);
      check("no boot erase", {31'h0, eraseSeen}, 32'h0);
      execInBoot <= 1'b1;
      vectorsInApp <= 1'b1;
      lpm(16'h7001);
      check("boot reads boot", {24'h0, lpmByte}, 32'hff);
      check("app irq mask", {31'h0, appIntMask}, 32'h1);
   endtask

   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      scn_reset();
      scn_page();
      scn_irq();
      scn_lock();
      report_and_stop();
   end
endmodule // testbench

`default_nettype wire
